/* gpio_cfg_pkg.sv */
`default_nettype none
// Summary of operation
// - Pull-down register low 16 bits enable each pin's pull-down resistor.
// - Pull-up register low 16 bits enable each pin's pull-up resistor.
// - With both pull bits set, only the pull-up is applied.
// - Port F pull-down resets with bit 3 set; ports A, B, C zero.
// - Four-bit selector per pin; 0000 plain port, 0001-0111 alternate functions.
// - Low selector holds pins 0-7, high holds 8-15, four bits each.
// - Analog select bit 0 gives digital function, 1 gives analog.
// - Analog select resets per port: A 9FFF, B FFFF, C E000, F 00C3.
// - Rising-edge enable bit makes a rising input edge an interrupt event.
// - Falling-edge enable bit makes a falling input edge an interrupt event.
// - Flag register shows one for each pin with a detected enabled edge.
// - Writing zero to a clear bit clears its flag; one has no effect.
// - Clear register reads ones in implemented bits; A,B FFFF, C E000, F 00CB.
// - Enabled filter suppresses pulses shorter than the filter clock period.
package gpio_cfg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PULL_DOWN   = 8'h0C;
  localparam logic [7:0] OFS_PULL_UP     = 8'h10;
  localparam logic [7:0] OFS_AF_HIGH     = 8'h14;
  localparam logic [7:0] OFS_AF_LOW      = 8'h18;
  localparam logic [7:0] OFS_ANALOG      = 8'h1C;
  localparam logic [7:0] OFS_RISE_EN     = 8'h24;
  localparam logic [7:0] OFS_FALL_EN     = 8'h28;
  localparam logic [7:0] OFS_FLAGS       = 8'h34;
  localparam logic [7:0] OFS_FLAG_CLEAR  = 8'h38;
  localparam logic [7:0] OFS_FILTER      = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h44;
  // Field layout
  localparam int PIN_COUNT     = 16;
  localparam int SEL_WIDTH     = 4;
  localparam int FLT_SEL_LSB   = 16;
  localparam int FLT_SEL_WIDTH = 3;
  // Port identities
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_F = 2'h3;
  // Reset values
  localparam logic [15:0] PD_RST_A  = 16'h0000;
  localparam logic [15:0] PD_RST_F  = 16'h0008;
  localparam logic [15:0] AN_RST_A  = 16'h9FFF;
  localparam logic [15:0] AN_RST_B  = 16'hFFFF;
  localparam logic [15:0] AN_RST_C  = 16'hE000;
  localparam logic [15:0] AN_RST_F  = 16'h00C3;
  localparam logic [15:0] ICR_RD_AB = 16'hFFFF;
  localparam logic [15:0] ICR_RD_C  = 16'hE000;
  localparam logic [15:0] ICR_RD_F  = 16'h00CB;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
  // Filter clock divider ratios for the core-clock derived selections
  localparam int FLT_DIV_2 = 2;
  localparam int FLT_DIV_4 = 4;
  localparam int FLT_DIV_8 = 8;
endpackage
`default_nettype wire

/* pin_sync.sv */
`default_nettype none
// Two-stage synchroniser for a bundle of asynchronous pins
module pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1_q;

  // First stage is read only by the second
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1_q <= '0;
      sync_o   <= '0;
    end
    else
    begin
      stage1_q <= async_i;
      sync_o   <= stage1_q;
    end
  end
endmodule
`default_nettype wire

/* pin_filter.sv */
`default_nettype none
// One pin's glitch filter: level must stay stable two filter ticks
module pin_filter (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  input  wire logic tick_i,
  input  wire logic level_i,
  output logic      level_o
);
  logic [1:0] stable_q;

  // Count ticks while the input differs from the accepted level
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stable_q <= 2'h0;
      level_o  <= 1'b0;
    end
    else if (!enable_i)
    begin
      stable_q <= 2'h0;
      level_o  <= level_i;
    end
    else if (level_i == level_o)
    begin
      stable_q <= 2'h0;
    end
    else if (tick_i)
    begin
      if (stable_q == 2'h1)
      begin
        level_o  <= level_i;
        stable_q <= 2'h0;
      end
      else
      begin
        stable_q <= stable_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* gpio_port_cfg.sv */
`default_nettype none
// Pin configuration and edge interrupt block for one 16-pin port
module gpio_port_cfg #(
  parameter logic [1:0] PORT_ID = gpio_cfg_pkg::PORT_A
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             avs_response_err_o,
  // Pins and external triggers
  input  wire logic [15:0] pin_in_i,
  input  wire logic        ext_tick_a_i,
  input  wire logic        ext_tick_b_i,
  input  wire logic        ext_tick_c_i,
  input  wire logic        ext_tick_d_i,
  input  wire logic        ext_tick_e_i,
  output logic      [15:0] pull_up_on_o,
  output logic      [15:0] pull_down_on_o,
  output logic      [15:0] analog_mode_o,
  output logic      [63:0] pin_function_selector_o,
  output logic             irq_o
);
  localparam int N = gpio_cfg_pkg::PIN_COUNT;

  // Per-port reset and implemented-bit patterns
  localparam logic [15:0] PD_RST = (PORT_ID == gpio_cfg_pkg::PORT_F) ?
                                   gpio_cfg_pkg::PD_RST_F : gpio_cfg_pkg::PD_RST_A;
  localparam logic [15:0] AN_RST = (PORT_ID == gpio_cfg_pkg::PORT_A) ? gpio_cfg_pkg::AN_RST_A :
                                   (PORT_ID == gpio_cfg_pkg::PORT_B) ? gpio_cfg_pkg::AN_RST_B :
                                   (PORT_ID == gpio_cfg_pkg::PORT_C) ? gpio_cfg_pkg::AN_RST_C :
                                   gpio_cfg_pkg::AN_RST_F;
  localparam logic [15:0] IMPL   = (PORT_ID == gpio_cfg_pkg::PORT_C) ? gpio_cfg_pkg::ICR_RD_C :
                                   (PORT_ID == gpio_cfg_pkg::PORT_F) ? gpio_cfg_pkg::ICR_RD_F :
                                   gpio_cfg_pkg::ICR_RD_AB;

  logic        rst_meta_q;
  logic        rst_n_q;
  logic [15:0] pull_down_enable_q;
  logic [15:0] pull_up_enable_q;
  logic [31:0] alt_function_high_pins_q;
  logic [31:0] alt_function_low_pins_q;
  logic [15:0] analog_digital_select_q;
  logic [15:0] rising_edge_irq_enable_q;
  logic [15:0] falling_edge_irq_enable_q;
  logic [15:0] edge_irq_flags_q;
  logic [15:0] irq_mask_q;
  logic [15:0] filter_enable_q;
  logic [2:0]  filter_clock_select_q;
  logic [15:0] pin_sync;
  logic [15:0] pin_filt;
  logic [15:0] pin_prev_q;
  logic [15:0] edge_hit;
  logic [15:0] clear_mask;
  logic [2:0]  div_q;
  logic [4:0]  ext_meta_q;
  logic [4:0]  ext_sync_q;
  logic [4:0]  ext_prev_q;
  logic        flt_tick;
  logic        access_q;
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic        rd_err;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Byte-enable write mask
  always_comb
  begin
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  end

  // One wait cycle per access, answered on the second
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      access_q <= 1'b0;
    else
      access_q <= (avs_read_i || avs_write_i) && !access_q;
  end
  assign wr_hit = avs_write_i && access_q;

  // Pull and function configuration registers
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pull_down_enable_q       <= PD_RST;
      pull_up_enable_q         <= 16'h0000;
      alt_function_high_pins_q <= 32'h0000_0000;
      alt_function_low_pins_q  <= 32'h0000_0000;
      analog_digital_select_q  <= AN_RST;
    end
    else if (wr_hit)
    begin
      if (avs_address_i == gpio_cfg_pkg::OFS_PULL_DOWN)
        pull_down_enable_q <= (pull_down_enable_q & ~wmask[15:0])
                              | (avs_writedata_i[15:0] & wmask[15:0]);
      else if (avs_address_i == gpio_cfg_pkg::OFS_PULL_UP)
        pull_up_enable_q <= (pull_up_enable_q & ~wmask[15:0])
                            | (avs_writedata_i[15:0] & wmask[15:0]);
      else if (avs_address_i == gpio_cfg_pkg::OFS_AF_HIGH)
        alt_function_high_pins_q <= (alt_function_high_pins_q & ~wmask)
                                    | (avs_writedata_i & wmask);
      else if (avs_address_i == gpio_cfg_pkg::OFS_AF_LOW)
        alt_function_low_pins_q <= (alt_function_low_pins_q & ~wmask)
                                   | (avs_writedata_i & wmask);
      else if (avs_address_i == gpio_cfg_pkg::OFS_ANALOG)
        analog_digital_select_q <= (analog_digital_select_q & ~wmask[15:0])
                                   | (avs_writedata_i[15:0] & wmask[15:0]);
    end
  end

  // Interrupt enable, mask and filter registers
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rising_edge_irq_enable_q  <= 16'h0000;
      falling_edge_irq_enable_q <= 16'h0000;
      irq_mask_q                <= 16'hFFFF;
      filter_enable_q           <= 16'h0000;
      filter_clock_select_q     <= 3'h0;
    end
    else if (wr_hit)
    begin
      if (avs_address_i == gpio_cfg_pkg::OFS_RISE_EN)
        rising_edge_irq_enable_q <= (rising_edge_irq_enable_q & ~wmask[15:0])
                                    | (avs_writedata_i[15:0] & wmask[15:0]);
      else if (avs_address_i == gpio_cfg_pkg::OFS_FALL_EN)
        falling_edge_irq_enable_q <= (falling_edge_irq_enable_q & ~wmask[15:0])
                                     | (avs_writedata_i[15:0] & wmask[15:0]);
      else if (avs_address_i == gpio_cfg_pkg::OFS_IRQ_MASK)
        irq_mask_q <= (irq_mask_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
      else if (avs_address_i == gpio_cfg_pkg::OFS_FILTER)
      begin
        filter_enable_q <= (filter_enable_q & ~wmask[15:0])
                           | (avs_writedata_i[15:0] & wmask[15:0]);
        if (avs_byteenable_i[2])
          filter_clock_select_q <= avs_writedata_i[gpio_cfg_pkg::FLT_SEL_LSB +:
                                                   gpio_cfg_pkg::FLT_SEL_WIDTH];
      end
    end
  end

  // Pin inputs synchronised to the core clock
  pin_sync #(
    .WIDTH (N)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_q),
    .async_i    (pin_in_i),
    .sync_o     (pin_sync)
  );

  // External filter ticks synchronised, second stage edge-detected
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ext_meta_q <= 5'h00;
      ext_sync_q <= 5'h00;
      ext_prev_q <= 5'h00;
      div_q      <= 3'h0;
    end
    else
    begin
      ext_meta_q <= {ext_tick_e_i, ext_tick_d_i, ext_tick_c_i, ext_tick_b_i, ext_tick_a_i};
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      div_q      <= div_q + 3'h1;
    end
  end

  // Filter tick from the selected source
  always_comb
  begin
    case (filter_clock_select_q)
      3'h0:    flt_tick = (div_q[0] == 1'b1);
      3'h1:    flt_tick = (div_q[1:0] == 2'(gpio_cfg_pkg::FLT_DIV_4 - 1));
      3'h2:    flt_tick = (div_q == 3'(gpio_cfg_pkg::FLT_DIV_8 - 1));
      default: flt_tick = ext_sync_q[filter_clock_select_q - 3'h3]
                          && !ext_prev_q[filter_clock_select_q - 3'h3];
    endcase
  end

  // Glitch filter per pin
  for (genvar g = 0; g < N; g++)
  begin : g_filt
    pin_filter u_pin_filter (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_q),
      .enable_i   (filter_enable_q[g]),
      .tick_i     (flt_tick),
      .level_i    (pin_sync[g]),
      .level_o    (pin_filt[g])
    );
  end

  // Previous sample and enabled edge detection
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      pin_prev_q <= 16'h0000;
    else
      pin_prev_q <= pin_filt;
  end
  assign edge_hit = ((pin_filt & ~pin_prev_q) & rising_edge_irq_enable_q)
                  | ((~pin_filt & pin_prev_q) & falling_edge_irq_enable_q);

  // Clear on written zeros in enabled bytes
  assign clear_mask = (wr_hit && avs_address_i == gpio_cfg_pkg::OFS_FLAG_CLEAR) ?
                      (~avs_writedata_i[15:0] & wmask[15:0] & IMPL) : 16'h0000;

  // Sticky flags, set wins over clear
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      edge_irq_flags_q <= 16'h0000;
    else
      edge_irq_flags_q <= ((edge_irq_flags_q & ~clear_mask) | edge_hit) & IMPL;
  end

  // Read data decode
  always_comb
  begin
    rdata  = gpio_cfg_pkg::RD_ZERO;
    rd_err = 1'b0;
    if (avs_address_i == gpio_cfg_pkg::OFS_PULL_DOWN)
      rdata = {16'h0000, pull_down_enable_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_PULL_UP)
      rdata = {16'h0000, pull_up_enable_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_AF_HIGH)
      rdata = alt_function_high_pins_q;
    else if (avs_address_i == gpio_cfg_pkg::OFS_AF_LOW)
      rdata = alt_function_low_pins_q;
    else if (avs_address_i == gpio_cfg_pkg::OFS_ANALOG)
      rdata = {16'h0000, analog_digital_select_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_RISE_EN)
      rdata = {16'h0000, rising_edge_irq_enable_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_FALL_EN)
      rdata = {16'h0000, falling_edge_irq_enable_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_FLAGS)
      rdata = {16'h0000, edge_irq_flags_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_FLAG_CLEAR)
      rdata = {16'h0000, IMPL};
    else if (avs_address_i == gpio_cfg_pkg::OFS_FILTER)
      rdata = {13'h0000, filter_clock_select_q, filter_enable_q};
    else if (avs_address_i == gpio_cfg_pkg::OFS_IRQ_MASK)
      rdata = {16'h0000, irq_mask_q};
    else
      rd_err = 1'b1;
  end

  // Bus answer registers
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      avs_readdata_o     <= 32'h0000_0000;
      avs_waitrequest_o  <= 1'b1;
      avs_response_err_o <= 1'b0;
    end
    else
    begin
      avs_waitrequest_o  <= !((avs_read_i || avs_write_i) && !access_q);
      avs_response_err_o <= 1'b0;
      if (avs_read_i && !access_q)
      begin
        avs_readdata_o     <= rdata;
        avs_response_err_o <= rd_err;
      end
    end
  end

  // Pad control and function outputs
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pull_up_on_o            <= 16'h0000;
      pull_down_on_o          <= PD_RST;
      analog_mode_o           <= AN_RST;
      pin_function_selector_o <= 64'h0;
      irq_o                   <= 1'b0;
    end
    else
    begin
      pull_up_on_o            <= pull_up_enable_q;
      pull_down_on_o          <= pull_down_enable_q & ~pull_up_enable_q;
      analog_mode_o           <= analog_digital_select_q;
      pin_function_selector_o <= {alt_function_high_pins_q, alt_function_low_pins_q};
      irq_o                   <= |(edge_irq_flags_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

/* port_cfg_monitor.sv */
`default_nettype none
module port_cfg_monitor (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic        avs_waitrequest_o,
  input  wire logic        avs_response_err_o,
  input  wire logic [15:0] pin_in_i,
  input  wire logic [15:0] pull_up_on_o,
  input  wire logic [15:0] pull_down_on_o,
  input  wire logic [15:0] analog_mode_o,
  input  wire logic [63:0] pin_function_selector_o,
  input  wire logic        irq_o
);
  logic [15:0] pin_prev_q;
  logic [3:0]  pin_age_q;
  logic [3:0]  wr_age_q;
  logic [31:0] wd_q;
  logic        wr_acc;
  logic        full_wr;
  // Accepted write, and one with all lanes on
  assign wr_acc  = avs_write_i && !avs_waitrequest_o;
  assign full_wr = wr_acc && avs_byteenable_i == 4'hF;
  // Age of the last pin change and last write, saturating
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      pin_prev_q <= 16'h0000;
      pin_age_q  <= 4'h0;
      wr_age_q   <= 4'h0;
      wd_q       <= 32'h0000_0000;
    end
    else
    begin
      pin_prev_q <= pin_in_i;
      pin_age_q  <= (pin_in_i != pin_prev_q) ? 4'h0 : pin_age_q + {3'h0, pin_age_q != 4'hF};
      wr_age_q   <= wr_acc ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
      wd_q       <= wr_acc ? avs_writedata_i : wd_q;
    end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_pull_prio: assert property ((pull_up_on_o & pull_down_on_o) == 16'h0000)
    else $error("pull-down on together with pull-up");
  a_pull_up_wr: assert property (full_wr && avs_address_i == gpio_cfg_pkg::OFS_PULL_UP
    |-> ##[1:2] pull_up_on_o == wd_q[15:0]) else $error("pull-up output wrong");
  a_pull_dn_wr: assert property (full_wr && avs_address_i == gpio_cfg_pkg::OFS_PULL_DOWN
    |-> ##[1:2] pull_down_on_o == (wd_q[15:0] & ~pull_up_on_o))
    else $error("pull-down output wrong");
  a_analog_wr: assert property (full_wr && avs_address_i == gpio_cfg_pkg::OFS_ANALOG
    |-> ##[1:2] analog_mode_o == wd_q[15:0]) else $error("analog output wrong");
  a_sel_low: assert property (full_wr && avs_address_i == gpio_cfg_pkg::OFS_AF_LOW
    |-> ##[1:2] pin_function_selector_o[31:0] == wd_q) else $error("low selector wrong");
  a_sel_high: assert property (full_wr && avs_address_i == gpio_cfg_pkg::OFS_AF_HIGH
    |-> ##[1:2] pin_function_selector_o[63:32] == wd_q) else $error("high selector wrong");
  a_irq_cause: assert property ($rose(irq_o) |-> pin_age_q < 4'd12 || wr_age_q < 4'd4)
    else $error("interrupt rose without a cause");
  a_irq_clear: assert property ($fell(irq_o) |-> wr_age_q < 4'd4)
    else $error("interrupt fell without a write");
  a_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low two cycles");
  a_answer_next: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("answer not one cycle after request");
  a_err_read: assert property (avs_response_err_o |-> avs_read_i && !avs_waitrequest_o)
    else $error("error outside a read answer");
endmodule
bind gpio_port_cfg port_cfg_monitor u_port_cfg_monitor (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_err_o(avs_response_err_o), .pin_in_i(pin_in_i),
  .pull_up_on_o(pull_up_on_o), .pull_down_on_o(pull_down_on_o),
  .analog_mode_o(analog_mode_o), .pin_function_selector_o(pin_function_selector_o),
  .irq_o(irq_o));
`default_nettype wire

/* pin_env_model.sv */
`default_nettype none
module pin_env_model (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] drive_en_i,
  input  wire logic [15:0] drive_val_i,
  input  wire logic [15:0] pull_up_on_i,
  input  wire logic [15:0] pull_down_on_i,
  output logic      [15:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] float_q = 16'h0000;
  // Undriven, unpulled pins wander every cycle
  always_ff @(posedge core_clk_i)
    float_q <= ~float_q;
  // Driver wins, then pull-up over pull-down, else floating
  assign pin_o = (drive_en_i & drive_val_i)
    | (~drive_en_i & (pull_up_on_i | (~pull_down_on_i & float_q)));
endmodule
`default_nettype wire

/* test_port_pin_config_edge_irq.sv */
`default_nettype none
module test_port_pin_config_edge_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic [7:0]  address    = 8'h00;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wdata      = 32'h0000_0000;
  logic [3:0]  be         = 4'hF;
  logic [4:0]  ticks      = 5'h00;
  logic [15:0] drv_en     = 16'hFFFF;
  logic [15:0] drv_val    = 16'h0000;
  logic [31:0] rdata;
  logic        waitreq;
  logic        err;
  logic [15:0] pins;
  logic [15:0] pu;
  logic [15:0] pd;
  logic [15:0] an;
  logic [63:0] sel;
  logic        irq;
  logic [31:0] got;
  logic [31:0] mdl [logic [7:0]];
  logic [7:0]  rw_ofs [7];
  int          fail_count = 0;
  int          n_tests    = 0;
  gpio_port_cfg #(.PORT_ID(gpio_cfg_pkg::PORT_F)) u_gpio_port_cfg (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(address),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .avs_response_err_o(err),
    .pin_in_i(pins), .ext_tick_a_i(ticks[0]), .ext_tick_b_i(ticks[1]),
    .ext_tick_c_i(ticks[2]), .ext_tick_d_i(ticks[3]), .ext_tick_e_i(ticks[4]),
    .pull_up_on_o(pu), .pull_down_on_o(pd), .analog_mode_o(an),
    .pin_function_selector_o(sel), .irq_o(irq));
  pin_env_model u_pin_env_model (
    .core_clk_i(core_clk_i), .drive_en_i(drv_en), .drive_val_i(drv_val),
    .pull_up_on_i(pu), .pull_down_on_i(pd), .pin_o(pins));
  // Clock and free-running filter sources
  initial
    forever #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
    ticks <= 5'($urandom);
  // Compare one value with its expectation
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One Avalon transfer, with model update and read compare
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int          n;
    logic [31:0] m;
    n = 0;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    @(posedge core_clk_i);
    address <= a;
    wdata   <= d;
    be      <= b;
    wr      <= w;
    rd      <= !w;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (waitreq !== 1'b0 && n < 40);
    got = rdata;
    chk({31'h0, waitreq}, 32'h0);
    if (!w)
      chk({31'h0, err}, {31'h0, !mdl.exists(a)});
    wr <= 1'b0;
    rd <= 1'b0;
    if (w && a == gpio_cfg_pkg::OFS_FLAG_CLEAR)
      mdl[gpio_cfg_pkg::OFS_FLAGS] &= ~(~d & m & 32'h0000_FFFF);
    else if (w && mdl.exists(a) && a != gpio_cfg_pkg::OFS_FLAGS)
      mdl[a] = (mdl[a] & ~m) | (d & m);
    if (!w)
      chk(got, mdl.exists(a) ? mdl[a] : 32'h0000_0000);
  endtask
  // Move driven pins and fold enabled edges into the model
  task automatic pin_step(input logic [15:0] nv);
    logic [15:0] ed;
    ed = (mdl[gpio_cfg_pkg::OFS_RISE_EN][15:0] & nv & ~drv_val)
       | (mdl[gpio_cfg_pkg::OFS_FALL_EN][15:0] & ~nv & drv_val);
    @(posedge core_clk_i);
    drv_val <= nv;
    repeat (12) @(posedge core_clk_i);
    mdl[gpio_cfg_pkg::OFS_FLAGS] |= {16'h0000, ed & gpio_cfg_pkg::ICR_RD_F};
  endtask
  // Output pins against the register model
  task automatic out_chk();
    chk({16'h0, pu}, {16'h0, mdl[gpio_cfg_pkg::OFS_PULL_UP][15:0]});
    chk({16'h0, pd}, mdl[gpio_cfg_pkg::OFS_PULL_DOWN] & ~mdl[gpio_cfg_pkg::OFS_PULL_UP]);
    chk({16'h0, an}, mdl[gpio_cfg_pkg::OFS_ANALOG]);
    chk(sel[31:0], mdl[gpio_cfg_pkg::OFS_AF_LOW]);
    chk(sel[63:32], mdl[gpio_cfg_pkg::OFS_AF_HIGH]);
    chk({31'h0, irq}, {31'h0, |(mdl[gpio_cfg_pkg::OFS_FLAGS] & mdl[gpio_cfg_pkg::OFS_IRQ_MASK])});
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    $display("watchdog expired");
    finish_test();
  end
  initial
  begin
    void'($urandom(32'hA5251E5C));
    rw_ofs = '{gpio_cfg_pkg::OFS_PULL_DOWN, gpio_cfg_pkg::OFS_PULL_UP, gpio_cfg_pkg::OFS_AF_HIGH,
      gpio_cfg_pkg::OFS_AF_LOW, gpio_cfg_pkg::OFS_ANALOG, gpio_cfg_pkg::OFS_RISE_EN,
      gpio_cfg_pkg::OFS_FALL_EN};
    mdl[gpio_cfg_pkg::OFS_PULL_DOWN]  = 32'h0000_0008;
    mdl[gpio_cfg_pkg::OFS_PULL_UP]    = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_AF_HIGH]    = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_AF_LOW]     = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_ANALOG]     = 32'h0000_00C3;
    mdl[gpio_cfg_pkg::OFS_RISE_EN]    = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_FALL_EN]    = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_FLAGS]      = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_FLAG_CLEAR] = 32'h0000_00CB;
    mdl[gpio_cfg_pkg::OFS_FILTER]     = 32'h0000_0000;
    mdl[gpio_cfg_pkg::OFS_IRQ_MASK]   = 32'h0000_FFFF;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    // Reset values, outputs and unmapped reads
    foreach (mdl[k])
      if (k != gpio_cfg_pkg::OFS_IRQ_MASK)
        bus(1'b0, k, 32'h0, 4'hF);
    out_chk();
    bus(1'b0, 8'h00, 32'h0, 4'hF);
    bus(1'b0, 8'h48, 32'h0, 4'hF);
    $display("reset test done");
    // Random configuration with lane masks, upper halves zero except in the two selector registers
    for (int i = 0; i < 8; i++)
    begin
      for (int j = 0; j < 7; j++)
        bus(1'b1, rw_ofs[j], ((j == 2 || j == 3) ? 32'h7777_7777 : 32'h0000_FFFF) &
          ((i == 0) ? 32'h7654_3210 : $urandom), (i == 0) ? 4'hF : 4'($urandom));
      bus(1'b1, gpio_cfg_pkg::OFS_FLAGS, $urandom & 32'h0000_FFFF, 4'hF);
      bus(1'b1, 8'h48, $urandom, 4'hF);
      foreach (rw_ofs[j])
        bus(1'b0, rw_ofs[j], 32'h0, 4'hF);
      bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
      bus(1'b0, 8'h48, 32'h0, 4'hF);
      out_chk();
    end
    $display("config test done");
    // Floating pins with edges disabled raise nothing
    bus(1'b1, gpio_cfg_pkg::OFS_RISE_EN, 32'h0, 4'hF);
    bus(1'b1, gpio_cfg_pkg::OFS_FALL_EN, 32'h0, 4'hF);
    bus(1'b1, gpio_cfg_pkg::OFS_PULL_UP, 32'h0, 4'hF);
    bus(1'b1, gpio_cfg_pkg::OFS_PULL_DOWN, 32'h0, 4'hF);
    @(posedge core_clk_i);
    drv_en <= 16'h0000;
    repeat (20) @(posedge core_clk_i);
    drv_en <= 16'hFFFF;
    repeat (12) @(posedge core_clk_i);
    bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
    // Random edge enables, masks, pin moves and partial clears
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b1, gpio_cfg_pkg::OFS_RISE_EN, $urandom & 32'h0000_FFFF, 4'hF);
      bus(1'b1, gpio_cfg_pkg::OFS_FALL_EN, $urandom & 32'h0000_FFFF, 4'hF);
      bus(1'b1, gpio_cfg_pkg::OFS_IRQ_MASK, $urandom & 32'h0000_FFFF, 4'hF);
      pin_step(16'($urandom));
      bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
      out_chk();
      bus(1'b1, gpio_cfg_pkg::OFS_FLAG_CLEAR, $urandom & 32'h0000_FFFF, 4'hF);
      bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
      bus(1'b0, gpio_cfg_pkg::OFS_FLAG_CLEAR, 32'h0, 4'hF);
      out_chk();
    end
    bus(1'b1, gpio_cfg_pkg::OFS_FLAG_CLEAR, 32'h0, 4'hF);
    bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
    out_chk();
    // Filtered pins drop a one-cycle pulse and pass a held change
    bus(1'b1, gpio_cfg_pkg::OFS_FILTER, 32'h0000_FFFF, 4'hF);
    bus(1'b0, gpio_cfg_pkg::OFS_FILTER, 32'h0, 4'hF);
    bus(1'b1, gpio_cfg_pkg::OFS_RISE_EN, 32'h0000_FFFF, 4'hF);
    bus(1'b1, gpio_cfg_pkg::OFS_FALL_EN, 32'h0000_FFFF, 4'hF);
    @(posedge core_clk_i);
    drv_val <= ~drv_val;
    @(posedge core_clk_i);
    drv_val <= ~drv_val;
    repeat (12) @(posedge core_clk_i);
    bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
    pin_step(~drv_val);
    bus(1'b0, gpio_cfg_pkg::OFS_FLAGS, 32'h0, 4'hF);
    out_chk();
    $display("edge test done");
    finish_test();
  end
endmodule
`default_nettype wire
